/* src/rftps_pkg.sv */
// Purpose: Shared constants and carriers for the RF transmitter sequencer
// Assumes: 50 MHz clock; the host does all packet framing
// Notes: Times are kept in microseconds; cycle counts derive from them
//
// Overview of operation
// R01: Power up, lock and raise ready within 10 ms of supply.
// R02: Retune to a new channel and carry valid data within 1.5 ms.
// R03: Pass the data stream unchanged, adding no encoding or framing.
// R04: Power control low or supply lost shuts everything down at once.
// R05: Host waits the full lock interval after every re-power before data.
// R06: Host may start sending as soon as ready goes high.
// R07: Host drops power control after each transmission.
// R08: Host sends each packet as bytes with no idle gaps.
// R09: Host opens packets with an all-ones sync byte, start byte, payload.
// R10: Sync byte holds the line high for at least one byte period.
// R11: Receiver sees high-to-low as start bit; avoid alternating preambles.
// R12: Host's start byte value never appears inside payload.
// R13: Each packet carries a checksum or CRC; failures are dropped.
// R14: Ready goes high once the synthesizer is locked and data is accepted.
// R15: Without ready, host waits at least 10 ms after power on.
// R16: Host raises power control, then watches ready.
// R17: Host steps off, powering, wait, sync, start, payload, check, off.
// R18: Host flags a timeout if ready misses turn-on time plus margin.

`default_nettype none

package rftps_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLOCK_MHZ = 50;
    localparam int TURN_ON_TIME_US = 10000;
    localparam int CHANNEL_SWITCH_TIME_US = 1500;
    // Longest times convert exactly to whole cycles
    localparam int TURN_ON_CYCLES = TURN_ON_TIME_US * CLOCK_MHZ;
    localparam int CHANNEL_SWITCH_CYCLES = CHANNEL_SWITCH_TIME_US * CLOCK_MHZ;

    // ****************************************************************
    // Widths and reset values
    // ****************************************************************
    localparam int CHANNEL_W = 3;
    localparam logic [CHANNEL_W-1:0] CHANNEL_RESET = 3'h0;
    // Data line idles low while the carrier is off
    localparam logic DATA_IDLE = 1'b0;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic power_on_ctl;
        logic supply_ok;
        logic [CHANNEL_W-1:0] channel_sel;
    } rftps_ctl_t;

    typedef struct packed {
        logic carrier_on;
        logic tx_data;
        logic [CHANNEL_W-1:0] channel;
    } rftps_rf_t;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_LOCKING,
        ST_READY,
        ST_RETUNE
    } rftps_state_t;

endpackage : rftps_pkg

`default_nettype wire

/* src/rftps_lock_timer.sv */
// Purpose: Down counter that times synthesizer lock and retune
// Assumes: start is single-cycle (a held start reloads every cycle), abort single-cycle or level, abort wins
// Notes: expired is a one-cycle pulse when the loaded count runs out

`timescale 1ns/1ps
`default_nettype none

module rftps_lock_timer #(
    parameter int COUNT_W = 20
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic start,
    input wire logic abort,
    input wire logic [COUNT_W-1:0] limit,
    output logic expired
);
    import rftps_pkg::*;

    typedef struct packed {
        logic busy;
        logic expired;
        logic [COUNT_W-1:0] count;
    } rftps_timer_state_t;

    rftps_timer_state_t s_q;
    rftps_timer_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.expired = 1'b0;
        if (abort) begin
            s_d.busy = 1'b0;
            s_d.count = '0;
        end else if (start) begin
            s_d.busy = 1'b1;
            s_d.count = limit;
        end else if (s_q.busy) begin
            if (s_q.count <= COUNT_W'(1)) begin
                s_d.busy = 1'b0;
                s_d.expired = 1'b1;
                s_d.count = '0;
            end else begin
                s_d.count = s_q.count - COUNT_W'(1);
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign expired = s_q.expired;

endmodule : rftps_lock_timer

`default_nettype wire

/* src/rftps_transmitter.sv */
// Purpose: Power, lock and transparent data path of the RF transmitter
// Assumes: Inputs synchronous to clock; host frames every packet
// Notes: Lock and retune delays are parameters so simulation can shrink them

`timescale 1ns/1ps
`default_nettype none

module rftps_transmitter #(
    parameter int LOCK_CYCLES = rftps_pkg::TURN_ON_CYCLES,
    parameter int RETUNE_CYCLES = rftps_pkg::CHANNEL_SWITCH_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire rftps_pkg::rftps_ctl_t ctl,
    input wire logic data_in,
    output logic ready,
    output rftps_pkg::rftps_rf_t rf
);
    import rftps_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    localparam int COUNT_W = $clog2(LOCK_CYCLES + RETUNE_CYCLES + 2);

    typedef struct packed {
        rftps_state_t state;
        logic ready;
        rftps_rf_t rf;
    } rftps_tx_state_t;

    rftps_tx_state_t s_q;
    rftps_tx_state_t s_d;

    logic powered;
    logic channel_moved;
    logic timer_start;
    logic timer_abort;
    logic timer_expired;
    logic [COUNT_W-1:0] timer_limit;

    // Either a dropped enable or a lost supply counts as power down
    assign powered = ctl.power_on_ctl & ctl.supply_ok;
    assign channel_moved = ctl.channel_sel != s_q.rf.channel;

    // ****************************************************************
    // Lock timer
    // ****************************************************************
    // One timer serves both delays; they never overlap in time
    rftps_lock_timer #(
        .COUNT_W(COUNT_W)
    ) u_timer (
        .clock(clock),
        .reset_n(reset_n),
        .start(timer_start),
        .abort(timer_abort),
        .limit(timer_limit),
        .expired(timer_expired)
    );

    // ****************************************************************
    // Sequencing and data path
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        timer_start = 1'b0;
        timer_abort = 1'b0;
        timer_limit = COUNT_W'(LOCK_CYCLES);
        case (s_q.state)
            ST_OFF: begin
                if (powered) begin
                    s_d.state = ST_LOCKING;
                    s_d.rf.channel = ctl.channel_sel;
                    timer_start = 1'b1; // R01
                end
            end
            ST_LOCKING: begin
                // Follow a selection made during lock; lock covers it
                s_d.rf.channel = ctl.channel_sel;
                if (timer_expired) begin
                    s_d.state = ST_READY;
                    s_d.ready = 1'b1; // R14
                    s_d.rf.carrier_on = 1'b1;
                end
            end
            ST_READY: begin
                if (channel_moved) begin
                    s_d.state = ST_RETUNE;
                    s_d.ready = 1'b0;
                    s_d.rf.carrier_on = 1'b0;
                    s_d.rf.channel = ctl.channel_sel;
                    timer_limit = COUNT_W'(RETUNE_CYCLES);
                    timer_start = 1'b1; // R02
                end
            end
            ST_RETUNE: begin
                if (channel_moved) begin
                    // A fresh selection restarts the retune window
                    s_d.rf.channel = ctl.channel_sel;
                    timer_limit = COUNT_W'(RETUNE_CYCLES);
                    timer_start = 1'b1; // R02
                end else if (timer_expired) begin
                    s_d.state = ST_READY;
                    s_d.ready = 1'b1; // R14
                    s_d.rf.carrier_on = 1'b1;
                end
            end
            default: begin
                s_d.state = ST_OFF;
            end
        endcase

        // Bits pass straight through, one cycle late, no reshaping
        if (s_d.rf.carrier_on) begin
            s_d.rf.tx_data = data_in; // R03
        end else begin
            s_d.rf.tx_data = DATA_IDLE;
        end

        // Power loss overrides everything but the channel, including a pending expiry
        if (!powered) begin
            s_d.state = ST_OFF; // R04
            s_d.ready = 1'b0; // R04
            s_d.rf.carrier_on = 1'b0; // R04
            s_d.rf.tx_data = DATA_IDLE;
            timer_start = 1'b0;
            timer_abort = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_q.state <= ST_OFF;
            s_q.ready <= 1'b0;
            s_q.rf.carrier_on <= 1'b0;
            s_q.rf.tx_data <= DATA_IDLE;
            s_q.rf.channel <= CHANNEL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign ready = s_q.ready;
    assign rf = s_q.rf;

endmodule : rftps_transmitter

`default_nettype wire

/* tb/rftps_sva.sv */
// Purpose: Port properties of the transmitter
// Assumes: Small lock and retune counts
// Notes: Sees only the top ports
`timescale 1ns/1ps
`default_nettype none
module rftps_sva #(
    parameter int LOCK_CYCLES = 20,
    parameter int RETUNE_CYCLES = 8
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire rftps_pkg::rftps_ctl_t ctl,
    input wire logic data_in,
    input wire logic ready,
    input wire rftps_pkg::rftps_rf_t rf
);
    import rftps_pkg::*;
    localparam int LK = LOCK_CYCLES + 3;
    localparam int RT = RETUNE_CYCLES + 3;
    logic pw;
    assign pw = ctl.power_on_ctl && ctl.supply_ok;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // ****
    // Checks
    // ****
    lock_bound_a: assert property ($rose(pw) |-> ##[1:LK] (ready || !pw))
        else $error("ready late");
    lock_early_a: assert property ($rose(pw) |-> !ready [*8])
        else $error("ready early");
    retune_time_a: assert property (
        ready && pw && ctl.channel_sel != rf.channel
        |=> !ready ##[1:RT] (ready || !pw)) else $error("retune late");
    data_pass_a: assert property (
        rf.carrier_on && $past(rf.carrier_on) |-> rf.tx_data == $past(data_in))
        else $error("data altered");
    power_off_a: assert property (
        !pw |=> !ready && !rf.carrier_on && rf.tx_data == DATA_IDLE)
        else $error("not shut down");
    ready_carrier_a: assert property (ready |-> rf.carrier_on)
        else $error("ready without carrier");
    ready_channel_a: assert property (
        ready && $past(ready) |-> $stable(rf.channel))
        else $error("channel moved while ready");
    cover property ($rose(ready));
    cover property (ready && ctl.channel_sel != rf.channel);
    cover property (rf.carrier_on && rf.tx_data);
endmodule : rftps_sva
bind rftps_transmitter rftps_sva #(.LOCK_CYCLES(LOCK_CYCLES),
    .RETUNE_CYCLES(RETUNE_CYCLES)) u_sva (.clock(clock), .reset_n(reset_n),
    .ctl(ctl), .data_in(data_in), .ready(ready), .rf(rf));
`default_nettype wire

/* tb/rftps_host_model.sv */
// Purpose: Host that powers up, frames one packet and powers down
// Assumes: One bit per clock, driven at the falling edge
// Notes: Runs once per simulation
`timescale 1ns/1ps
`default_nettype none
module rftps_host_model (
    input wire logic clock,
    input wire logic go,
    input wire logic ready,
    input wire logic [7:0] pay,
    output var rftps_pkg::rftps_ctl_t ctl,
    output logic data_in,
    output logic done,
    output logic timeout
);
    import rftps_pkg::*;
    // Must never occur inside the payload
    localparam logic [7:0] START_BYTE = 8'hA5;
    logic [39:0] frame;
    int n;
    // ****
    // Sequence
    // ****
    // High stop bits after all-ones sync give a clean start edge
    assign frame = {1'b1, START_BYTE + pay, 1'b0, 1'b1, pay, 1'b0,
        1'b1, START_BYTE, 1'b0, 1'b1, 8'hFF, 1'b0};
    initial begin
        ctl = '0;
        data_in = 1'b0;
        done = 1'b0;
        timeout = 1'b0;
        wait (go);
        @(negedge clock);
        ctl = {1'b1, 1'b1, 3'h5};
        for (n = 0; n < 200 && ready !== 1'b1; n++) begin
            @(negedge clock);
        end
        timeout = (n == 200);
        for (n = 0; n < 40; n++) begin
            data_in = frame[n];
            @(negedge clock);
        end
        data_in = 1'b0;
        ctl.power_on_ctl = 1'b0;
        done = 1'b1;
    end
endmodule : rftps_host_model
`default_nettype wire

/* tb/rf_tx_packet_sequencer_bench.sv */
// Purpose: Self-checking bench of the transmitter
// Assumes: Shortened lock and retune counts
// Notes: Bench or host model drives the inputs
`timescale 1ns/1ps
`default_nettype none
module rf_tx_packet_sequencer_bench;
    import rftps_pkg::*;
    localparam int LOCK = 20;
    localparam int RET = 8;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic use_host = 1'b0;
    logic go = 1'b0;
    logic b_data = 1'b0;
    logic h_data, ready, done, tmo;
    logic [39:0] got;
    rftps_ctl_t b_ctl = '0;
    rftps_ctl_t h_ctl;
    rftps_rf_t rf;
    int failures = 0;
    int checks = 0;
    always #10 clock = ~clock;
    rftps_transmitter #(.LOCK_CYCLES(LOCK), .RETUNE_CYCLES(RET)) DUT (
        .clock(clock), .reset_n(reset_n), .ctl(use_host ? h_ctl : b_ctl),
        .data_in(use_host ? h_data : b_data), .ready(ready), .rf(rf));
    rftps_host_model u_host (.clock(clock), .go(go), .ready(ready),
        .pay(8'h3C), .ctl(h_ctl), .data_in(h_data), .done(done),
        .timeout(tmo));
    // ****
    // Tasks
    // ****
    task automatic check(string what, logic [39:0] seen, logic [39:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task automatic wait_ready(output int n);
        for (n = 0; n < 100 && ready !== 1'b1; n++) @(negedge clock);
        if (n == 100) begin
            failures++;
            conclude();
        end
    endtask : wait_ready
    task automatic t_lock();
        int n;
        b_ctl = {1'b1, 1'b1, 3'h2};
        b_data = 1'b1;
        repeat (10) @(negedge clock);
        b_ctl.supply_ok = 1'b0;
        @(negedge clock);
        check("abort", {rf.carrier_on, ready}, 40'h0);
        b_ctl.supply_ok = 1'b1;
        wait_ready(n);
        check("lock", n >= LOCK && n <= LOCK + 3, 40'h1);
        @(negedge clock);
        check("pass", rf.tx_data, 40'h1);
        b_ctl.supply_ok = 1'b0;
        @(negedge clock);
        check("supply off", {rf.carrier_on, ready, rf.tx_data}, 40'h0);
        b_ctl.supply_ok = 1'b1;
        wait_ready(n);
        check("relock", n >= LOCK && n <= LOCK + 3, 40'h1);
        b_data = 1'b0;
        $display("lock test done");
    endtask : t_lock
    task automatic t_retune();
        int n;
        b_ctl.channel_sel = 3'h7;
        @(negedge clock);
        check("retune", {rf.channel, ready}, {3'h7, 1'b0});
        wait_ready(n);
        check("retune time", n <= RET + 3, 40'h1);
        $display("retune test done");
    endtask : t_retune
    task automatic t_packet();
        int n;
        b_ctl = '0;
        repeat (2) @(negedge clock);
        use_host = 1'b1;
        go = 1'b1;
        wait_ready(n);
        for (n = 0; n < 40; n++) begin
            @(negedge clock);
            got[n] = rf.tx_data;
        end
        check("frame", got, {1'b1, 8'hE1, 1'b0, 1'b1, 8'h3C, 1'b0,
            1'b1, 8'hA5, 1'b0, 1'b1, 8'hFF, 1'b0});
        check("host wait", tmo, 40'h0);
        repeat (2) @(negedge clock);
        check("off", {done, ready, rf.carrier_on}, 40'h4);
        $display("packet test done");
    endtask : t_packet
    initial begin
        repeat (10) @(negedge clock);
        reset_n = 1'b1;
        t_lock();
        t_retune();
        t_packet();
        conclude();
    end
endmodule : rf_tx_packet_sequencer_bench
`default_nettype wire
